// ---- logic/ciu_pkg.sv ----
// constants, opcodes and state type shared by the compare instruction unit
package ciu_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // first bytes and second bytes of the handled compare group
  localparam logic [7:0] OPC_PFX8 = 8'hCE;      // prefix for 8-bit memory forms
  localparam logic [7:0] OPC_PFX16 = 8'hCF;     // prefix for 16-bit pair forms
  localparam logic [7:0] OPC_HL_IMM = 8'h35;    // memory pointer location vs immediate
  localparam logic [7:0] OPC_HL_IDX = 8'h36;    // 36/37: low bit picks index register
  localparam logic [7:0] OPC_BA_RP = 8'h18;     // 18..1B: accumulator pair vs pair
  localparam logic [7:0] OPC_HL_RP = 8'h38;     // 38..3B: memory pointer vs pair
  localparam logic [7:0] OPC_SP_RP = 8'h5C;     // 5C/5D: stack pointer vs pair
  localparam logic [7:0] OPC_SP_IMM = 8'h6C;    // stack pointer vs 16-bit immediate
  localparam logic [7:0] OPC_IMM16 = 8'hD4;     // D4..D7: pair vs 16-bit immediate

  ////////////////////////////////////////////////////////////////////////////////
  // cycle counts per instruction form
  localparam int CYC_LONG = 4;                  // prefixed forms
  localparam int CYC_SHORT = 3;                 // single opcode with immediate word

  ////////////////////////////////////////////////////////////////////////////////
  // flag byte layout: high nibble is interrupt level, unpack and decimal
  localparam int FLG_Z = 0;                     // zero
  localparam int FLG_C = 1;                     // carry (borrow)
  localparam int FLG_V = 2;                     // overflow
  localparam int FLG_N = 3;                     // sign

  ////////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [7:0] FLAGS_RST = 8'h00;     // flag image after reset
  localparam logic [7:0] PAGE_FLAT = 8'h00;     // page used outside the banked models
  localparam logic [15:0] WORD_RST = 16'h0000;  // operand and result registers
  localparam logic [23:0] ADDR_RST = 24'h000000; // memory address register
  localparam logic READY_RST = 1'b1;            // idle takes bytes at once

  // sequencer states
  typedef enum logic [3:0] {
    S_IDLE, S_PFX_CE, S_PFX_CF, S_IMM8, S_IMM_LO, S_IMM_HI,
    S_RD_HL, S_WT_HL, S_RD_IR, S_WT_IR, S_EXEC
  } ciu_state_t;

endpackage : ciu_pkg

// ---- logic/ciu_core_if.sv ----
// carrier between the sequencer, the subtractor and the address former
`timescale 1ns/1ns
`default_nettype none
interface ciu_core_if;
  logic [15:0] alu_a;     // minuend
  logic [15:0] alu_b;     // subtrahend
  logic alu_wide;         // 1: 16-bit compare
  logic [15:0] alu_diff;  // difference
  logic alu_n;            // sign of difference
  logic alu_v;            // signed overflow
  logic alu_c;            // unsigned borrow
  logic alu_z;            // difference is zero
  logic agu_idx;          // 1: index-pointed access
  logic agu_idx_sel;      // 0: first index, 1: second index
  logic [15:0] agu_hl;    // memory pointer pair
  logic [15:0] agu_ix;    // first index register
  logic [15:0] agu_iy;    // second index register
  logic [7:0] agu_ep;     // extended page
  logic [7:0] agu_xp;     // first index page
  logic [7:0] agu_yp;     // second index page
  logic agu_banked;       // banked memory model active
  logic [23:0] agu_addr;  // page and offset

  modport core (output alu_a, alu_b, alu_wide, agu_idx, agu_idx_sel, agu_hl, agu_ix,
                agu_iy, agu_ep, agu_xp, agu_yp, agu_banked,
                input alu_diff, alu_n, alu_v, alu_c, alu_z, agu_addr);
  modport alu (input alu_a, alu_b, alu_wide, output alu_diff, alu_n, alu_v, alu_c, alu_z);
  modport agu (input agu_idx, agu_idx_sel, agu_hl, agu_ix, agu_iy, agu_ep, agu_xp, agu_yp,
               agu_banked, output agu_addr);
endinterface : ciu_core_if
`default_nettype wire

// ---- logic/ciu_sub_unit.sv ----
// subtractor and flag former for 8- and 16-bit compares
`timescale 1ns/1ns
`default_nettype none
module ciu_sub_unit
  import ciu_pkg::*;
(
  ciu_core_if.alu bus  // operands in, difference and flags out
);
  ////////////////////////////////////////////////////////////////////////////////
  // both widths computed in parallel, the width bit picks one
  logic [16:0] d16;   // 16-bit difference with borrow
  logic [8:0] d8;     // 8-bit difference with borrow
  logic a_msb;        // sign of minuend at the chosen width
  logic b_msb;        // sign of subtrahend at the chosen width
  assign d16 = {1'b0, bus.alu_a} - {1'b0, bus.alu_b};
  assign d8 = {1'b0, bus.alu_a[7:0]} - {1'b0, bus.alu_b[7:0]};
  assign bus.alu_diff = bus.alu_wide ? d16[15:0] : {8'h00, d8[7:0]};
  assign a_msb = bus.alu_wide ? bus.alu_a[15] : bus.alu_a[7];
  assign b_msb = bus.alu_wide ? bus.alu_b[15] : bus.alu_b[7];
  // sign, borrow, zero and overflow at operand width
  assign bus.alu_n = bus.alu_wide ? d16[15] : d8[7];
  assign bus.alu_c = bus.alu_wide ? d16[16] : d8[8];
  assign bus.alu_z = (bus.alu_diff == WORD_RST);
  // overflow only when signs differ and the result left the minuend's sign
  assign bus.alu_v = (a_msb != b_msb) && (bus.alu_n != a_msb);
endmodule : ciu_sub_unit
`default_nettype wire

// ---- logic/ciu_addr_unit.sv ----
// forms the paged data address for memory operands
`timescale 1ns/1ns
`default_nettype none
module ciu_addr_unit
  import ciu_pkg::*;
(
  ciu_core_if.agu bus  // pointer selection in, full address out
);
  logic [7:0] page;   // page part of the address
  logic [15:0] ptr;   // offset part of the address
  // index page follows the index register in use
  assign page = !bus.agu_banked ? PAGE_FLAT :
                !bus.agu_idx ? bus.agu_ep :
                bus.agu_idx_sel ? bus.agu_yp : bus.agu_xp;
  assign ptr = !bus.agu_idx ? bus.agu_hl : (bus.agu_idx_sel ? bus.agu_iy : bus.agu_ix);
  assign bus.agu_addr = {page, ptr};
endmodule : ciu_addr_unit
`default_nettype wire

// ---- logic/ciu_compare_unit.sv ----
// sequencer for the compare instruction group: decode, operand fetch, flag update
`timescale 1ns/1ns
`default_nettype none
module ciu_compare_unit
  import ciu_pkg::*;
#(
  parameter int CYC_W = 4  // width of the instruction cycle counter
) (
  input wire logic mclk,                  // core clock, 25 MHz
  input wire logic rst_n,                 // asynchronous reset, active low
  input wire logic code_valid,            // instruction byte offered
  input wire logic [7:0] code_byte,       // instruction byte
  output logic code_ready,                // byte will be taken this cycle
  output logic mem_rd,                    // one-cycle data read request
  output logic [23:0] mem_addr,           // page and offset of the read
  input wire logic mem_rvalid,            // read data present
  input wire logic [7:0] mem_rdata,       // read data
  input wire logic [15:0] reg_ba,         // accumulator pair
  input wire logic [15:0] memory_pointer_pair, // memory pointer pair
  input wire logic [15:0] first_index_reg,     // first index register
  input wire logic [15:0] second_index_reg,    // second index register
  input wire logic [15:0] stack_pointer_reg,   // stack pointer
  input wire logic [7:0] extended_page_reg,    // page for pointer accesses
  input wire logic [7:0] first_index_page_reg, // page for first index
  input wire logic [7:0] second_index_page_reg, // page for second index
  input wire logic banked_memory_models,  // banked model selected
  input wire logic [7:0] flags_in,        // current flag byte
  output logic [7:0] flags_out,           // new flag byte
  output logic flags_we,                  // one-cycle write of flags_out
  output logic busy,                      // instruction in progress
  output logic not_mine                   // byte taken is not a handled compare
);

  ////////////////////////////////////////////////////////////////////////////////
  // elaboration check: the counter must reach the longest count
  if (CYC_W < 3) begin : g_chk
    $error("CYC_W too small for the instruction cycle counts");
  end

  localparam logic [CYC_W-1:0] CNT_LONG = CYC_W'(CYC_LONG);   // prefixed forms
  localparam logic [CYC_W-1:0] CNT_SHORT = CYC_W'(CYC_SHORT); // single opcode immediate word forms
  localparam logic [CYC_W-1:0] CNT_ONE = CYC_W'(1);           // count at first byte
  localparam logic [CYC_W-1:0] CNT_MAX = {CYC_W{1'b1}};       // saturation point

  ciu_core_if bus ();  // shared carrier with the two helpers

  ciu_sub_unit u_sub (
    .bus (bus)
  );

  ciu_addr_unit u_addr (
    .bus (bus)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // state and data registers
  ciu_state_t state_ff, nxt_state;     // sequencer
  logic code_ready_ff;                 // byte acceptance
  logic [CYC_W-1:0] cyc_ff, nxt_cyc;   // cycles since the first byte
  logic [CYC_W-1:0] need_ff, nxt_need; // fewest cycles this instruction takes
  logic [15:0] opa_ff, nxt_opa;        // destination operand
  logic [15:0] opb_ff, nxt_opb;        // source operand
  logic wide_ff, nxt_wide;             // 16-bit compare
  logic idx_op_ff, nxt_idx_op;         // second read from index location
  logic idx_sel_ff, nxt_idx_sel;       // which index register
  logic mem_rd_ff;                     // read request pulse
  logic [23:0] mem_addr_ff;            // read address
  logic [7:0] flags_ff;                // flag result
  logic flags_we_ff;                   // flag write pulse
  logic busy_ff;                       // in progress
  logic not_mine_ff;                   // foreign byte pulse
  logic [15:0] res_ff;                 // last difference, kept for checking

  ////////////////////////////////////////////////////////////////////////////////
  // byte decode, all as named wires
  logic take;          // byte accepted on this edge
  logic is_pfx8;       // 8-bit prefix
  logic is_pfx16;      // 16-bit prefix
  logic is_imm16;      // D4..D7 single opcodes
  logic ce_hl_imm;     // second byte 35
  logic ce_hl_idx;     // second byte 36/37
  logic cf_pair;       // 18..1B or 38..3B
  logic cf_sp_rp;      // 5C/5D
  logic cf_sp_imm;     // 6C
  logic cf_known;      // any handled byte after 16-bit prefix
  logic ce_known;      // any handled byte after 8-bit prefix
  logic commit;        // flags written on this edge
  logic [15:0] pair_lo2;  // pair picked by the two-bit select field
  logic [15:0] cf_dst;    // destination picked by the second byte
  logic [15:0] cf_src;    // source picked by the second byte

  assign take = code_valid && code_ready_ff;
  assign is_pfx8 = (code_byte == OPC_PFX8);
  assign is_pfx16 = (code_byte == OPC_PFX16);
  assign is_imm16 = (code_byte[7:2] == OPC_IMM16[7:2]);
  assign ce_hl_imm = (code_byte == OPC_HL_IMM);
  assign ce_hl_idx = (code_byte[7:1] == OPC_HL_IDX[7:1]);
  assign cf_pair = (code_byte[7:2] == OPC_BA_RP[7:2]) || (code_byte[7:2] == OPC_HL_RP[7:2]);
  assign cf_sp_rp = (code_byte[7:1] == OPC_SP_RP[7:1]);
  assign cf_sp_imm = (code_byte == OPC_SP_IMM);
  assign cf_known = cf_pair || cf_sp_rp || cf_sp_imm;
  assign ce_known = ce_hl_imm || ce_hl_idx;
  assign commit = (state_ff == S_EXEC) && (cyc_ff >= need_ff);

  // the two-bit pair select field: 00 acc pair, 01 pointer, 10/11 index
  assign pair_lo2 = (code_byte[1:0] == 2'h0) ? reg_ba :
                    (code_byte[1:0] == 2'h1) ? memory_pointer_pair :
                    (code_byte[1:0] == 2'h2) ? first_index_reg : second_index_reg;
  // bit 6 marks the stack pointer forms, bit 5 the pointer-pair forms
  assign cf_dst = code_byte[6] ? stack_pointer_reg :
                  code_byte[5] ? memory_pointer_pair : reg_ba;
  assign cf_src = cf_sp_rp ? (code_byte[0] ? memory_pointer_pair : reg_ba) : pair_lo2;

  ////////////////////////////////////////////////////////////////////////////////
  // carrier hook-up: operands to the subtractor, pointers to the address former
  assign bus.alu_a = opa_ff;
  assign bus.alu_b = opb_ff;
  assign bus.alu_wide = wide_ff;
  assign bus.agu_idx = (state_ff == S_RD_IR);
  assign bus.agu_idx_sel = idx_sel_ff;
  assign bus.agu_hl = memory_pointer_pair;
  assign bus.agu_ix = first_index_reg;
  assign bus.agu_iy = second_index_reg;
  assign bus.agu_ep = extended_page_reg;
  assign bus.agu_xp = first_index_page_reg;
  assign bus.agu_yp = second_index_page_reg;
  assign bus.agu_banked = banked_memory_models;

  ////////////////////////////////////////////////////////////////////////////////
  // next state: bytes in order, then reads, then wait out the cycle count
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      S_IDLE: begin
        if (take && is_pfx8) nxt_state = S_PFX_CE;
        else if (take && is_pfx16) nxt_state = S_PFX_CF;
        else if (take && is_imm16) nxt_state = S_IMM_LO;
      end
      S_PFX_CE: begin
        if (take) nxt_state = ce_hl_imm ? S_IMM8 : (ce_hl_idx ? S_RD_HL : S_IDLE);
      end
      S_PFX_CF: begin
        if (take) nxt_state = cf_sp_imm ? S_IMM_LO : ((cf_pair || cf_sp_rp) ? S_EXEC : S_IDLE);
      end
      S_IMM8: if (take) nxt_state = S_RD_HL;
      S_IMM_LO: if (take) nxt_state = S_IMM_HI;       // low byte first
      S_IMM_HI: if (take) nxt_state = S_EXEC;         // then high byte
      S_RD_HL: nxt_state = S_WT_HL;
      S_WT_HL: if (mem_rvalid) nxt_state = idx_op_ff ? S_RD_IR : S_EXEC;
      S_RD_IR: nxt_state = S_WT_IR;
      S_WT_IR: if (mem_rvalid) nxt_state = S_EXEC;
      S_EXEC: if (commit) nxt_state = S_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // operand capture; memory bytes arrive zero-extended into the low lane
  always_comb begin
    nxt_opa = opa_ff;
    nxt_opb = opb_ff;
    nxt_wide = wide_ff;
    nxt_need = need_ff;
    nxt_idx_op = idx_op_ff;
    nxt_idx_sel = idx_sel_ff;
    if (take && state_ff == S_IDLE) begin
      nxt_wide = !is_pfx8;
      nxt_need = is_imm16 ? CNT_SHORT : CNT_LONG;
      nxt_opa = pair_lo2;                            // D4..D7
    end
    if (take && state_ff == S_PFX_CE) begin
      nxt_idx_op = ce_hl_idx;
      nxt_idx_sel = code_byte[0];                    // index select bit
    end
    if (take && state_ff == S_PFX_CF) begin
      nxt_opa = cf_dst;
      nxt_opb = cf_src;
    end
    if (take && state_ff == S_IMM8) nxt_opb = {8'h00, code_byte};
    if (take && state_ff == S_IMM_LO) nxt_opb[7:0] = code_byte;
    if (take && state_ff == S_IMM_HI) nxt_opb[15:8] = code_byte;
    if (mem_rvalid && state_ff == S_WT_HL) nxt_opa = {8'h00, mem_rdata};
    if (mem_rvalid && state_ff == S_WT_IR) nxt_opb = {8'h00, mem_rdata};
  end

  // cycle counter: one at the first byte, saturating so a long wait cannot wrap
  assign nxt_cyc = (take && state_ff == S_IDLE) ? CNT_ONE :
                   (state_ff == S_IDLE) ? '0 :
                   (cyc_ff == CNT_MAX) ? cyc_ff : cyc_ff + CNT_ONE;

  ////////////////////////////////////////////////////////////////////////////////
  // sequencer and counter registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= S_IDLE;
      cyc_ff <= '0;
      code_ready_ff <= READY_RST;
      busy_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cyc_ff <= nxt_cyc;
      code_ready_ff <= (nxt_state inside {S_IDLE, S_PFX_CE, S_PFX_CF, S_IMM8,
                                          S_IMM_LO, S_IMM_HI});
      busy_ff <= (nxt_state != S_IDLE);
    end
  end

  // operand registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      opa_ff <= WORD_RST;
      opb_ff <= WORD_RST;
      wide_ff <= 1'b0;
      need_ff <= CNT_LONG;
      idx_op_ff <= 1'b0;
      idx_sel_ff <= 1'b0;
    end else begin
      opa_ff <= nxt_opa;
      opb_ff <= nxt_opb;
      wide_ff <= nxt_wide;
      need_ff <= nxt_need;
      idx_op_ff <= nxt_idx_op;
      idx_sel_ff <= nxt_idx_sel;
    end
  end

  // read port: request only, there is no write path so operands stay intact
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mem_rd_ff <= 1'b0;
      mem_addr_ff <= ADDR_RST;
    end else begin
      mem_rd_ff <= (state_ff == S_RD_HL) || (state_ff == S_RD_IR);
      if (state_ff == S_RD_HL || state_ff == S_RD_IR) mem_addr_ff <= bus.agu_addr;
    end
  end

  // flag result: low nibble from the subtractor, high nibble passed through
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      flags_ff <= FLAGS_RST;
      flags_we_ff <= 1'b0;
      res_ff <= WORD_RST;
    end else begin
      flags_we_ff <= commit;
      if (commit) flags_ff <= {flags_in[7:4], bus.alu_n, bus.alu_v,
                               bus.alu_c, bus.alu_z};
      if (commit) res_ff <= bus.alu_diff;
    end
  end

  // foreign byte: lets the core hand the byte to another decoder
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) not_mine_ff <= 1'b0;
    else not_mine_ff <= take && ((state_ff == S_IDLE && !is_pfx8 && !is_pfx16 && !is_imm16)
                                 || (state_ff == S_PFX_CE && !ce_known)
                                 || (state_ff == S_PFX_CF && !cf_known));
  end

  assign code_ready = code_ready_ff;
  assign mem_rd = mem_rd_ff;
  assign mem_addr = mem_addr_ff;
  assign flags_out = flags_ff;
  assign flags_we = flags_we_ff;
  assign busy = busy_ff;
  assign not_mine = not_mine_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_take_d4;
    state_ff == S_IDLE && take && code_byte == OPC_IMM16 ##1 take ##1 take;
  endsequence
  property p_d4_len;
    @(posedge mclk) disable iff (!rst_n) s_take_d4 |-> !flags_we_ff ##1 !flags_we_ff ##1 flags_we_ff;
  endproperty
  a_d4_len: assert property (p_d4_len) else $error("immediate word compare length wrong");
  property p_min_len;
    @(posedge mclk) disable iff (!rst_n) flags_we_ff |-> $past(cyc_ff) >= $past(need_ff);
  endproperty
  a_min_len: assert property (p_min_len) else $error("flags written too early");
  property p_keep_high;
    @(posedge mclk) disable iff (!rst_n) flags_we_ff |-> flags_ff[7:4] == $past(flags_in[7:4]);
  endproperty
  a_keep_high: assert property (p_keep_high) else $error("high flag nibble altered");
  property p_zero;
    @(posedge mclk) disable iff (!rst_n) flags_we_ff |-> flags_ff[FLG_Z] == (res_ff == WORD_RST);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag mismatch");
  property p_sign;
    @(posedge mclk) disable iff (!rst_n)
      flags_we_ff |-> flags_ff[FLG_N] == ($past(wide_ff) ? res_ff[15] : res_ff[7]);
  endproperty
  a_sign: assert property (p_sign) else $error("sign flag mismatch");
  property p_rd_pulse;
    @(posedge mclk) disable iff (!rst_n) mem_rd_ff |=> !mem_rd_ff;
  endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("read request longer than one cycle");
  property p_page_hl;
    @(posedge mclk) disable iff (!rst_n) mem_rd_ff && $past(state_ff == S_RD_HL) && $past(banked_memory_models)
      |-> mem_addr_ff == {$past(extended_page_reg), $past(memory_pointer_pair)};
  endproperty
  a_page_hl: assert property (p_page_hl) else $error("pointer access page wrong");
  property p_page_ir;
    @(posedge mclk) disable iff (!rst_n) mem_rd_ff && $past(state_ff == S_RD_IR) && $past(banked_memory_models)
      |-> mem_addr_ff[23:16] == ($past(idx_sel_ff) ? $past(second_index_page_reg)
                                                  : $past(first_index_page_reg));
  endproperty
  a_page_ir: assert property (p_page_ir) else $error("index access page wrong");
  property p_two_reads;
    @(posedge mclk) disable iff (!rst_n)
      state_ff == S_WT_HL && mem_rvalid && idx_op_ff |=> state_ff == S_RD_IR ##1 mem_rd_ff;
  endproperty
  a_two_reads: assert property (p_two_reads) else $error("index read missing");
  property p_sp_imm;
    @(posedge mclk) disable iff (!rst_n)
      state_ff == S_PFX_CF && take && cf_sp_imm |=> state_ff == S_IMM_LO && opa_ff == $past(stack_pointer_reg);
  endproperty
  a_sp_imm: assert property (p_sp_imm) else $error("stack pointer immediate decode wrong");

endmodule : ciu_compare_unit
`default_nettype wire

// ---- test/compare_instruction_unit_tb.sv ----
// self-checking bench for the compare instruction unit
`timescale 1ns/1ns
`default_nettype none
module compare_instruction_unit_tb;
  import ciu_pkg::*;
  logic mclk = 1'b0, rst_n = 1'b0, code_valid = 1'b0, mem_rvalid = 1'b0;
  logic banked_memory_models = 1'b0; // page select mode
  logic [7:0] code_byte = 8'h00, mem_rdata = 8'h00, flags_in = 8'hA5, mh, mq;
  logic [15:0] reg_ba = 16'h3F71, memory_pointer_pair = 16'h53D1, first_index_reg = 16'hA291;
  logic [15:0] second_index_reg = 16'h2862, stack_pointer_reg = 16'h145A;
  logic [7:0] extended_page_reg = 8'h12, first_index_page_reg = 8'h34, second_index_page_reg = 8'h56;
  logic code_ready, mem_rd, flags_we, busy, not_mine;
  logic [23:0] mem_addr, pa, qa; // pa, qa: addresses the memory model will answer
  logic [7:0] flags_out;
  int err_total = 0, checks_done = 0, cyc = 0, t0;
  ciu_compare_unit ciu_compare_unit_i (.mclk, .rst_n, .code_valid, .code_byte, .code_ready,
    .mem_rd, .mem_addr, .mem_rvalid, .mem_rdata, .reg_ba, .memory_pointer_pair,
    .first_index_reg, .second_index_reg, .stack_pointer_reg, .extended_page_reg,
    .first_index_page_reg, .second_index_page_reg, .banked_memory_models, .flags_in,
    .flags_out, .flags_we, .busy, .not_mine);
  initial begin
    forever #20 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // cycle count and hang guard
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      err_total++;
      complete_run();
    end
  end
  // memory answers one cycle late; a wrong page or offset reads garbage, so flags go wrong
  always @(posedge mclk) begin
    mem_rvalid <= mem_rd;
    mem_rdata <= !mem_rd ? ~mem_rdata : mem_addr == pa ? mh : mem_addr == qa ? mq : 8'hEE;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // expected flag byte; 8-bit compares are passed shifted into the top byte
  function automatic logic [7:0] fl(input logic [15:0] a, input logic [15:0] b);
    logic [16:0] d;
    d = {1'b0, a} - {1'b0, b};
    return {flags_in[7:4], d[15], (a[15] ^ b[15]) & (a[15] ^ d[15]), d[16], d[15:0] == 16'h0000};
  endfunction : fl
  function automatic logic [15:0] rp(input int r);
    return r == 0 ? reg_ba : r == 1 ? memory_pointer_pair : r == 2 ? first_index_reg : second_index_reg;
  endfunction : rp
  // offer one byte and return just after the edge that takes it
  task automatic send(input logic [7:0] b);
    int n;
    n = 0;
    code_valid = 1'b1;
    code_byte = b;
    while (code_ready !== 1'b1 && n < 50) begin
      @(posedge mclk) #1;
      n++;
    end
    @(posedge mclk) #1;
  endtask : send
  // one instruction, first byte in the top used byte of bs; nc of 0 skips the cycle count
  task automatic ins(input logic [31:0] bs, input int nb, input logic [7:0] ef, input int nc);
    int n;
    n = 0;
    for (int i = nb - 1; i >= 0; i--) begin
      send(bs[8*i+:8]);
      if (i == nb - 1) t0 = cyc;
    end
    code_valid = 1'b0;
    while (flags_we !== 1'b1 && n < 50) begin
      @(posedge mclk) #1;
      n++;
    end
    chk("flags_out", {24'h0, flags_out}, {24'h0, ef});
    if (nc > 0) chk("cycles", cyc - t0, nc);
    chk("busy", {31'h0, busy}, 32'h0);
  endtask : ins
  task automatic bad(input logic [15:0] bs, input int nb);
    int n;
    n = 0;
    for (int i = nb - 1; i >= 0; i--) send(bs[8*i+:8]);
    code_valid = 1'b0;
    while (not_mine !== 1'b1 && n < 3) begin
      @(posedge mclk) #1;
      n++;
    end
    chk("not_mine", {31'h0, not_mine}, 32'h1);
    chk("flags_we", {31'h0, flags_we}, 32'h0);
  endtask : bad
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : complete_run
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence; instructions run back to back to exercise the hand-over cycle
  initial begin
    repeat (2) @(posedge mclk);
    chk("flags_out", {24'h0, flags_out}, {24'h0, FLAGS_RST});
    #1 rst_n = 1'b1;
    for (int r = 0; r < 4; r++) begin
      ins({16'h0, OPC_PFX16, OPC_BA_RP + 8'(r)}, 2, fl(reg_ba, rp(r)), 4);
      ins({16'h0, OPC_PFX16, OPC_HL_RP + 8'(r)}, 2, fl(rp(1), rp(r)), 4);
      ins({8'h0, OPC_IMM16 + 8'(r), 16'hD153}, 3, fl(rp(r), 16'h53D1), 3);
    end
    for (int r = 0; r < 2; r++)
      ins({16'h0, OPC_PFX16, OPC_SP_RP + 8'(r)}, 2, fl(stack_pointer_reg, rp(r)), 4);
    ins({OPC_PFX16, OPC_SP_IMM, 16'h5A14}, 4, fl(stack_pointer_reg, 16'h145A), 4);
    for (int k = 0; k < 2; k++) begin
      banked_memory_models = k[0];
      pa = {k[0] ? extended_page_reg : 8'h00, memory_pointer_pair};
      mh = 8'h3C;
      ins({8'h0, OPC_PFX8, OPC_HL_IMM, 8'h59}, 3, fl(16'h3C00, 16'h5900), 0);
      chk("mem_addr", {8'h0, mem_addr}, {8'h0, pa});
      mh = 8'hC3;
      mq = 8'h62;
      for (int r = 0; r < 2; r++) begin
        qa = {k[0] ? (r ? second_index_page_reg : first_index_page_reg) : 8'h00, rp(r + 2)};
        ins({16'h0, OPC_PFX8, OPC_HL_IDX + 8'(r)}, 2, fl(16'hC300, 16'h6200), 0);
        chk("mem_addr", {8'h0, mem_addr}, {8'h0, qa});
      end
    end
    bad(16'h0000, 1);
    bad({OPC_PFX16, 8'h00}, 2);
    flags_in = 8'h5A;
    ins({8'h0, OPC_IMM16, 16'h5A14}, 3, fl(reg_ba, 16'h145A), 3);
    complete_run();
  end
endmodule : compare_instruction_unit_tb
`default_nettype wire
